// file: rtl/scg_map.vh
// Register map, field positions and reset values of the sleep clock gating block
`ifndef SCG_MAP_VH
`define SCG_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SCG_RUN_GATE_OFS 12'h100
`define SCG_SLEEP_GATE_OFS 12'h110
`define SCG_DEEP_GATE_OFS 12'h120
`define SCG_RUN_CFG_OFS 12'h180
`define SCG_INT_STATUS_OFS 12'h190
`define SCG_INT_MASK_OFS 12'h194

// ----------------------------------------------------------------------------
// Field positions in the gating registers
// ----------------------------------------------------------------------------
`define SCG_PWM_BIT 20
`define SCG_ADC_BIT 16
`define SCG_SPEED_HI 9
`define SCG_SPEED_LO 8
`define SCG_WDOG_BIT 3
`define SCG_GATE_MASK 32'h00110308

// Auto clock gating bit in the run configuration register
`define SCG_AUTO_GATE_BIT 0
`define SCG_CFG_MASK 32'h00000001

// Fault status bits: 0 watchdog, 1 converter, 2 modulator
`define SCG_INT_MASK_BITS 32'h00000007

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SCG_GATE_RESET 32'h00000040
`define SCG_CFG_RESET 32'h00000000
`define SCG_INT_RESET 32'h00000000

// ----------------------------------------------------------------------------
// Converter sample speed codes
// ----------------------------------------------------------------------------
`define SCG_SPEED_500K 2'h2
`define SCG_SPEED_250K 2'h1
`define SCG_SPEED_125K 2'h0

`endif

// file: rtl/scg_clock_gate.v
// Sleep-mode clock gating control with APB register access and fault interrupt
`timescale 1ns/10ps
`include "scg_map.vh"

module scg_clock_gate #(
  parameter ADDR_WIDTH = 12,
  parameter UNITS = 3
) (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sleep_req,
  input wire deep_sleep_req,
  input wire [UNITS-1:0] unit_access,
  output reg [UNITS-1:0] unit_clk_en,
  output reg [UNITS-1:0] unit_fault,
  output reg [1:0] converter_sample_speed,
  output reg irq
);

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  reg [31:0] run_clock_gate_0;
  reg [31:0] sleep_clock_gate_0;
  reg [31:0] deep_sleep_clock_gate_0;
  reg [31:0] run_clock_configuration;
  reg [31:0] int_status;
  reg [31:0] int_mask;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire access_phase;
  wire commit;
  wire do_write;
  wire hit_run;
  wire hit_sleep;
  wire hit_deep;
  wire hit_cfg;
  wire hit_stat;
  wire hit_mask;
  wire mapped;
  wire [31:0] byte_mask;
  wire [ADDR_WIDTH-1:0] word_addr;

  assign access_phase = psel & penable;
  assign commit = access_phase & pready;
  assign do_write = commit & pwrite & ~pslverr;
  assign word_addr = {paddr[ADDR_WIDTH-1:2], 2'b00};
  assign hit_run = (word_addr == `SCG_RUN_GATE_OFS);
  assign hit_sleep = (word_addr == `SCG_SLEEP_GATE_OFS);
  assign hit_deep = (word_addr == `SCG_DEEP_GATE_OFS);
  assign hit_cfg = (word_addr == `SCG_RUN_CFG_OFS);
  assign hit_stat = (word_addr == `SCG_INT_STATUS_OFS);
  assign hit_mask = (word_addr == `SCG_INT_MASK_OFS);
  assign mapped = hit_run | hit_sleep | hit_deep | hit_cfg | hit_stat | hit_mask;
  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // --------------------------------------------------------------------------
  // Read data mux
  // --------------------------------------------------------------------------
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h00000000;
    if (hit_run) begin
      next_rdata = run_clock_gate_0 & `SCG_GATE_MASK;
    end else if (hit_sleep) begin
      next_rdata = sleep_clock_gate_0 & `SCG_GATE_MASK;
    end else if (hit_deep) begin
      next_rdata = deep_sleep_clock_gate_0 & `SCG_GATE_MASK;
    end else if (hit_cfg) begin
      next_rdata = run_clock_configuration & `SCG_CFG_MASK;
    end else if (hit_stat) begin
      next_rdata = int_status & `SCG_INT_MASK_BITS;
    end else if (hit_mask) begin
      next_rdata = int_mask & `SCG_INT_MASK_BITS;
    end
  end

  // --------------------------------------------------------------------------
  // APB handshake: one wait cycle, then ready with data
  // --------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (commit) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (access_phase) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= (pwrite | ~mapped) ? 32'h00000000 : next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Writable registers
  // --------------------------------------------------------------------------
  function [31:0] scg_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [31:0] lanes;
    input [31:0] keep;
    begin
      scg_merge = ((old_val & ~lanes) | (new_val & lanes)) & keep;
    end
  endfunction

  // Reserved bits are never stored, so the printed reset value leaves them
  // clear on readback
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      run_clock_gate_0 <= `SCG_GATE_RESET & `SCG_GATE_MASK;
      sleep_clock_gate_0 <= `SCG_GATE_RESET & `SCG_GATE_MASK;
      deep_sleep_clock_gate_0 <= `SCG_GATE_RESET & `SCG_GATE_MASK;
      run_clock_configuration <= `SCG_CFG_RESET;
      int_mask <= `SCG_INT_RESET;
    end else if (do_write) begin
      if (hit_run) begin
        run_clock_gate_0 <= scg_merge(run_clock_gate_0, pwdata, byte_mask,
          `SCG_GATE_MASK);
      end
      if (hit_sleep) begin
        sleep_clock_gate_0 <= scg_merge(sleep_clock_gate_0, pwdata, byte_mask,
          `SCG_GATE_MASK);
      end
      if (hit_deep) begin
        deep_sleep_clock_gate_0 <= scg_merge(deep_sleep_clock_gate_0, pwdata, byte_mask,
          `SCG_GATE_MASK);
      end
      if (hit_cfg) begin
        run_clock_configuration <= scg_merge(run_clock_configuration, pwdata, byte_mask,
          `SCG_CFG_MASK);
      end
      if (hit_mask) begin
        int_mask <= scg_merge(int_mask, pwdata, byte_mask, `SCG_INT_MASK_BITS);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Power mode selection
  // --------------------------------------------------------------------------
  wire auto_clock_gating;
  reg [31:0] active_gate;

  assign auto_clock_gating = run_clock_configuration[`SCG_AUTO_GATE_BIT];

  always @* begin
    active_gate = run_clock_gate_0;
    if (auto_clock_gating) begin
      if (deep_sleep_req) begin
        active_gate = deep_sleep_clock_gate_0;
      end else if (sleep_req) begin
        active_gate = sleep_clock_gate_0;
      end
    end
  end

  // Per-unit gate bits: 0 watchdog, 1 converter, 2 modulator
  wire [UNITS-1:0] next_clk_en;

  assign next_clk_en[0] = active_gate[`SCG_WDOG_BIT];
  assign next_clk_en[1] = active_gate[`SCG_ADC_BIT];
  assign next_clk_en[2] = active_gate[`SCG_PWM_BIT];

  // --------------------------------------------------------------------------
  // Clock enables, sample speed and unit faults
  // --------------------------------------------------------------------------
  wire [UNITS-1:0] fault_event;

  genvar gi;
  generate
    for (gi = 0; gi < UNITS; gi = gi + 1) begin : g_unit
      assign fault_event[gi] = unit_access[gi] & ~unit_clk_en[gi];

      always @(posedge ref_clk) begin
        if (!rst_n) begin
          unit_clk_en[gi] <= 1'b0;
          unit_fault[gi] <= 1'b0;
        end else begin
          unit_clk_en[gi] <= next_clk_en[gi];
          unit_fault[gi] <= fault_event[gi];
        end
      end
    end
  endgenerate

  // Speed field follows the register in force for the present mode
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      converter_sample_speed <= `SCG_SPEED_125K;
    end else begin
      converter_sample_speed <= active_gate[`SCG_SPEED_HI:`SCG_SPEED_LO];
    end
  end

  // --------------------------------------------------------------------------
  // Fault status and interrupt
  // --------------------------------------------------------------------------
  wire [31:0] status_clear;
  wire [31:0] status_set;
  wire [31:0] next_status;

  assign status_clear = (do_write & hit_stat) ? (pwdata & byte_mask) : 32'h00000000;
  assign status_set = {{(32-UNITS){1'b0}}, fault_event};
  // A fault in the same cycle as its clear stays set
  assign next_status = ((int_status & ~status_clear) | status_set) & `SCG_INT_MASK_BITS;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      int_status <= `SCG_INT_RESET;
      irq <= 1'b0;
    end else begin
      int_status <= next_status;
      irq <= |(next_status & int_mask);
    end
  end

endmodule // scg_clock_gate

// file: testbench/scg_clock_gate_assertions.sv
// Concurrent checks on the ports of the sleep clock gating block
`timescale 1ns/10ps
`include "scg_map.vh"
module scg_clock_gate_assertions #(
  parameter ADDR_WIDTH = 12,
  parameter UNITS = 3
) (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sleep_req,
  input wire deep_sleep_req,
  input wire [UNITS-1:0] unit_access,
  input wire [UNITS-1:0] unit_clk_en,
  input wire [UNITS-1:0] unit_fault,
  input wire [1:0] converter_sample_speed,
  input wire irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------------------
  // Write commits, faults, readback, reset and handshake
  // ----------------------------------------------------------------------------
  sequence run_wr_s;
    pready && psel && penable && pwrite && pstrb == 4'hf && paddr == `SCG_RUN_GATE_OFS
      && !sleep_req && !deep_sleep_req;
  endsequence
  sequence sleep_wr_s;
    pready && psel && penable && pwrite && paddr == `SCG_SLEEP_GATE_OFS
      && !sleep_req && !deep_sleep_req;
  endsequence
  gated_fault_a: assert property ($past(rst_n) |->
    unit_fault == $past(unit_access & ~unit_clk_en)) else $error("fault pulse wrong");
  run_enable_a: assert property (run_wr_s |-> ##2
    unit_clk_en == $past({pwdata[20], pwdata[16], pwdata[3]}, 2)) else $error("enable wrong");
  run_speed_a: assert property (run_wr_s |-> ##2
    converter_sample_speed == $past(pwdata[9:8], 2)) else $error("speed wrong");
  sleep_idle_a: assert property (sleep_wr_s |=> $stable(unit_clk_en) [*2])
    else $error("sleep set applied while running");
  reserved_zero_a: assert property (pready && !pwrite && paddr == `SCG_SLEEP_GATE_OFS
    |-> (prdata & ~`SCG_GATE_MASK) == 32'h0) else $error("reserved bit set");
  reset_quiet_a: assert property ($rose(rst_n) |-> unit_clk_en == 0 && !irq
    && !pready) else $error("outputs not quiet after reset");
  access_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("ready timing wrong");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  error_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("data outside ready");
endmodule // scg_clock_gate_assertions

// file: testbench/scg_unit_model.sv
// Peripheral units behind the gates: access strobes and registered clock-enable flags
`timescale 1ns/10ps
module scg_unit_model (
  input wire ref_clk,
  input wire [2:0] unit_clk_en,
  input wire [2:0] poke,
  output logic [2:0] unit_access,
  output logic [2:0] unit_alive
);
  // Each alive bit is its unit's clock enable, delayed by one cycle
  always @(posedge ref_clk) begin
    unit_alive <= unit_clk_en;
  end
  // One strobe per bus access to a unit, clocked or not
  assign unit_access = poke;
endmodule // scg_unit_model

// file: testbench/sleep_mode_clock_gating_bench.sv
// Self-checking bench of the sleep clock gating block
`timescale 1ns/10ps
`include "scg_map.vh"
module sleep_mode_clock_gating_bench;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sleep_req = 0, deep_sleep_req = 0, irq;
  logic [2:0] poke = 3'h0, unit_access, unit_clk_en, unit_fault, unit_alive;
  logic [1:0] converter_sample_speed;
  int fail_count = 0, samples_checked = 0;
  scg_clock_gate i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
    .deep_sleep_req(deep_sleep_req), .unit_access(unit_access), .unit_clk_en(unit_clk_en),
    .unit_fault(unit_fault), .converter_sample_speed(converter_sample_speed), .irq(irq));
  scg_unit_model i_units (.ref_clk(ref_clk), .unit_clk_en(unit_clk_en), .poke(poke),
    .unit_access(unit_access), .unit_alive(unit_alive));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task tally_and_finish;
    $display("checked %0d, failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ----------------------------------------------------------------------------
  // Bus and unit drivers
  // ----------------------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk) penable <= 1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      tally_and_finish();
    end
    r = prdata; e = pslverr; psel <= 0; penable <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
    chk(e, 0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0, r, e);
    chk(e, 1'b0);
    chk(r, exp);
  endtask
  task settle;
    repeat (2) @(posedge ref_clk);
  endtask
  task touch(input int i);
    @(posedge ref_clk) poke <= 3'h1 << i;
    @(posedge ref_clk) poke <= 3'h0;
    @(posedge ref_clk);
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task t_reset;
    rd(`SCG_SLEEP_GATE_OFS, 32'h0);
    rd(`SCG_DEEP_GATE_OFS, 32'h0);
    chk(unit_clk_en, 3'h0);
  endtask
  task t_run;
    for (int s = 0; s < 3; s++) begin
      wr(`SCG_RUN_GATE_OFS, `SCG_GATE_MASK & ~32'h300 | s << 8);
      settle();
      chk(unit_clk_en, 3'h7);
      chk(converter_sample_speed, s);
    end
    chk(unit_alive, 3'h7);
    wr(`SCG_RUN_GATE_OFS, 32'h00100000);
    settle();
    chk(unit_clk_en, 3'h4);
    wr(`SCG_SLEEP_GATE_OFS, 32'hfffffeff);
    rd(`SCG_SLEEP_GATE_OFS, `SCG_GATE_MASK & ~32'h100);
  endtask
  task t_fault;
    logic [31:0] r;
    logic e;
    wr(`SCG_RUN_GATE_OFS, 32'h0);
    wr(`SCG_INT_MASK_OFS, 32'h7);
    for (int i = 0; i < 3; i++) begin
      touch(i);
      chk(unit_fault, 3'h1 << i);
      rd(`SCG_INT_STATUS_OFS, 32'h1 << i);
      chk(irq, 1);
      wr(`SCG_INT_STATUS_OFS, 32'h1 << i);
      settle();
      chk(irq, 0);
    end
    wr(`SCG_INT_MASK_OFS, 32'h0);
    touch(0);
    chk(irq, 0);
    wr(`SCG_RUN_GATE_OFS, `SCG_GATE_MASK & ~32'h100);
    touch(1);
    chk(unit_fault, 3'h0);
    rd(`SCG_INT_STATUS_OFS, 32'h1);
    apb(0, 12'h1f0, 32'h0, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0);
  endtask
  task t_sleep;
    wr(`SCG_RUN_CFG_OFS, 32'h1);
    wr(`SCG_SLEEP_GATE_OFS, 32'h00010008);
    wr(`SCG_DEEP_GATE_OFS, 32'h00000008);
    wr(`SCG_RUN_GATE_OFS, 32'h00100000);
    @(posedge ref_clk) sleep_req <= 1;
    settle();
    chk(unit_clk_en, 3'h3);
    @(posedge ref_clk) deep_sleep_req <= 1;
    settle();
    chk(unit_clk_en, 3'h1);
    @(posedge ref_clk) deep_sleep_req <= 0;
    sleep_req <= 0;
    settle();
    chk(unit_clk_en, 3'h4);
    wr(`SCG_RUN_CFG_OFS, 32'h0);
    @(posedge ref_clk) sleep_req <= 1;
    settle();
    chk(unit_clk_en, 3'h4);
  endtask
  task t_rearm;
    wr(`SCG_SLEEP_GATE_OFS, 32'h00100008);
    @(posedge ref_clk) rst_n <= 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    rd(`SCG_SLEEP_GATE_OFS, 32'h0);
    rd(`SCG_INT_STATUS_OFS, 32'h0);
    chk(unit_clk_en, 3'h0);
    chk(irq, 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1;
    t_reset();
    t_run();
    t_fault();
    t_sleep();
    t_rearm();
    tally_and_finish();
  end
endmodule // sleep_mode_clock_gating_bench
bind scg_clock_gate scg_clock_gate_assertions #(.ADDR_WIDTH(ADDR_WIDTH), .UNITS(UNITS)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
  .unit_access(unit_access), .unit_clk_en(unit_clk_en), .unit_fault(unit_fault),
  .converter_sample_speed(converter_sample_speed), .irq(irq));
